// >>> rcs_regs.svh
// reset_clock_sequencer constants: offsets, bit positions, reset values, cycle counts
// assumes a 100 MHz single clock domain; included by bare name
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// register byte addresses on the plain register port
`define CAUSE_ADDR        8'h00
`define CTRL_ADDR         8'h04
`define STAT_ADDR         8'h08

// reset_cause_register bit positions
`define CAUSE_POR_BIT     7
`define CAUSE_PIN_BIT     6
`define CAUSE_WDG_BIT     5
`define CAUSE_OPC_BIT     4
`define CAUSE_ADR_BIT     3
`define CAUSE_MOD_BIT     2
`define CAUSE_LVI_BIT     1
`define CAUSE_POR_VALUE   8'h80

// control register bit positions
`define CTRL_SHORT_BIT    0
`define CTRL_STOPEN_BIT   1
`define CTRL_PLLSEL_BIT   2
`define CTRL_RESET_VALUE  8'h02

// sequence counts in reference clock cycles
`define LONG_DELAY        13'd4096
`define SHORT_DELAY       13'd32
`define PIN_DRIVE_CYCLES  13'd32
`define INTERNAL_RESET_TAIL_CYCLES  13'd32
`define PIN_MIN_CYCLES    13'd67
`define PIN_MIN_PORLVI    13'd4163

// reset vectors
`define VEC_USER          16'hFFFE
`define VEC_MONITOR       16'hFEFE

`endif

// >>> rcs_pkg.sv
// reset_clock_sequencer types
// assumes rcs_regs.svh holds the numeric constants
package rcs_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_POWER_WAIT, ST_PIN_DRIVE, ST_INTERNAL_RESET_TAIL, ST_STOP, ST_STOP_WAKE
  } seq_state_type;
  typedef logic [12:0] count_type;
endpackage : rcs_pkg

// >>> reset_clock_sequencer.sv
// reset and bus clock sequencer: reset sources, reset pin, clock enables, cause flags
// assumes one 100 MHz clock standing for the reference clock; async inputs synchronised here
//
// What this block does
// - bus clock enable is reference or pll over four
// - power resets gate clocks and pin for 4096
// - stop wake counts reference cycles before clocks resume
// - wait stops cpu clock, peripheral clock keeps running
// - every source asserts internal reset, selects vector
// - internal reset clears counter, pin reset does not
// - each source sets its own cause flag
// - pin flag needs 67 low, 4163 with power
// - internal sources drive pin 32, then 32 more
// - power resets hold pin 4096+32, then 32 more
// - power-on sets only its flag, enables clock output
// - watchdog overflow resets, sets flag, treated async
// - watchdog disable only by high voltage decode
// - illegal opcode, or disallowed stop, resets with flag
// - only unmapped opcode fetch causes address reset
// - monitor entry with erased vectors forces reset
// - stabilisation counter is thirteen bits wide
// - stop instruction clears the stabilisation counter
// - wake delay is 32 when short select set
// - counter runs freely after reset states end
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module reset_clock_sequencer
  import rcs_pkg::*;
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // reset sources
  input  wire logic       POWER_ON,
  input  wire logic       LOW_SUPPLY,
  input  wire logic       WATCHDOG_OVF,
  input  wire logic       BAD_OPCODE,
  input  wire logic       STOP_INSTR,
  input  wire logic       WAIT_INSTR,
  input  wire logic       OPCODE_FETCH,
  input  wire logic       UNMAPPED_ADDR,
  input  wire logic       MONITOR_MODE,
  input  wire logic       VECTORS_ERASED,
  input  wire logic       BREAK_STATE,
  input  wire logic       WAKE_EVENT,
  input  wire logic       PLL_LOCKED,
  // high voltage detectors
  input  wire logic       RST_PIN_HV,
  input  wire logic       IRQ_PIN_HV,
  // reset pin, open drain
  input  wire logic       RESET_PIN_N_IN,
  output logic            RESET_PIN_N_OUT,
  output logic            RESET_PIN_N_OE_N,
  // sequencer outputs
  output logic            INTERNAL_RESET,
  output logic            CLOCK_GEN_OUTPUT,
  output logic            CPU_CLK_EN,
  output logic            PERIPH_CLK_EN,
  output logic            WATCHDOG_ENABLE,
  output logic     [15:0] RESET_VECTOR
);
  import rcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pin and watchdog
  logic       pin_s1_r, pin_s2_r, wdg_s1_r, wdg_s2_r;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      wdg_s1_r <= 1'b0;
      wdg_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= RESET_PIN_N_IN;
      pin_s2_r <= pin_s1_r;
      wdg_s1_r <= WATCHDOG_OVF;
      wdg_s2_r <= wdg_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and source decode
  logic [7:0] ctrl_r;
  logic       wdg_dis;
  logic       opc_evt, adr_evt, mod_evt, pwr_evt, int_evt;
  seq_state_type state_r;
  logic       pin_driving;

  // disable only while a high voltage is present, so noise cannot latch it
  assign wdg_dis = (MONITOR_MODE && (RST_PIN_HV || IRQ_PIN_HV))
                 || (BREAK_STATE && RST_PIN_HV);
  assign opc_evt = BAD_OPCODE || (STOP_INSTR && !ctrl_r[`CTRL_STOPEN_BIT]);
  assign adr_evt = OPCODE_FETCH && UNMAPPED_ADDR;
  assign mod_evt = MONITOR_MODE && VECTORS_ERASED;
  assign pwr_evt = POWER_ON || LOW_SUPPLY;
  assign int_evt = pwr_evt || opc_evt || adr_evt || mod_evt
                 || (wdg_s2_r && !wdg_dis);

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ctrl_r <= `CTRL_RESET_VALUE;
    end else if (WR && ADDR == `CTRL_ADDR) begin
      ctrl_r <= WDATA & 8'h07;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stabilisation counter, thirteen bits
  count_type cnt_r;
  logic      short_r;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cnt_r <= '0;
    end else if (int_evt && state_r != ST_POWER_WAIT) begin
      cnt_r <= '0;
    end else if (state_r == ST_RUN && STOP_INSTR && ctrl_r[`CTRL_STOPEN_BIT]) begin
      cnt_r <= '0;
    end else if (state_r == ST_STOP) begin
      cnt_r <= '0;                                   // held at zero while oscillator is off
    end else if ((state_r == ST_PIN_DRIVE || state_r == ST_INTERNAL_RESET_TAIL)
                 && cnt_r == `PIN_DRIVE_CYCLES - 13'd1) begin
      cnt_r <= '0;
    end else if (state_r == ST_POWER_WAIT && cnt_r == `LONG_DELAY - 13'd1) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 13'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence state machine
  logic pwr_seq_r;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r   <= ST_POWER_WAIT;
      pwr_seq_r <= 1'b1;
      short_r   <= 1'b0;
    end else if (pwr_evt && state_r != ST_POWER_WAIT) begin
      state_r   <= ST_POWER_WAIT;
      pwr_seq_r <= 1'b1;
    end else if (int_evt && !pwr_evt && state_r != ST_PIN_DRIVE) begin
      state_r   <= ST_PIN_DRIVE;
      pwr_seq_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (!pin_s2_r) begin
            state_r <= ST_INTERNAL_RESET_TAIL;                 // pin reset holds processing
          end else if (STOP_INSTR && ctrl_r[`CTRL_STOPEN_BIT]) begin
            state_r <= ST_STOP;
          end
        end
        ST_POWER_WAIT: begin
          if (!pwr_evt && cnt_r == `LONG_DELAY - 13'd1) begin
            state_r <= ST_PIN_DRIVE;                 // then 32 more on the pin
          end
        end
        ST_PIN_DRIVE: begin
          if (cnt_r == `PIN_DRIVE_CYCLES - 13'd1) begin
            state_r <= ST_INTERNAL_RESET_TAIL;
          end
        end
        ST_INTERNAL_RESET_TAIL: begin
          if (!pin_s2_r) begin
            state_r <= ST_INTERNAL_RESET_TAIL;                 // external hold extends reset
          end else if (cnt_r == `INTERNAL_RESET_TAIL_CYCLES - 13'd1) begin
            state_r   <= ST_RUN;
            pwr_seq_r <= 1'b0;
          end
        end
        ST_STOP: begin
          if (WAKE_EVENT || BREAK_STATE || !pin_s2_r) begin
            short_r <= ctrl_r[`CTRL_SHORT_BIT];
            state_r <= ST_STOP_WAKE;
          end
        end
        ST_STOP_WAKE: begin
          if (cnt_r == (short_r ? `SHORT_DELAY : `LONG_DELAY) - 13'd1) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin low time measurement
  count_type pin_low_r;
  logic      pin_qual;
  always_ff @(posedge CLOCK) begin
    if (!RESETN || pin_s2_r) begin
      pin_low_r <= '0;
    end else if (pin_low_r != 13'h1FFF) begin
      pin_low_r <= pin_low_r + 13'd1;
    end
  end
  // self-driven low is not counted as an external reset
  assign pin_qual = !pin_driving
                 && pin_low_r == (pwr_seq_r ? `PIN_MIN_PORLVI : `PIN_MIN_CYCLES) - 13'd1;

  ////////////////////////////////////////////////////////////////////////////
  // reset cause register, sticky until the next power-on
  logic [7:0] cause_r;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cause_r <= `CAUSE_POR_VALUE;
    end else if (POWER_ON) begin
      cause_r <= `CAUSE_POR_VALUE;
    end else begin
      if (pin_qual)              cause_r[`CAUSE_PIN_BIT] <= 1'b1;
      if (wdg_s2_r && !wdg_dis)  cause_r[`CAUSE_WDG_BIT] <= 1'b1;
      if (opc_evt)               cause_r[`CAUSE_OPC_BIT] <= 1'b1;
      if (adr_evt)               cause_r[`CAUSE_ADR_BIT] <= 1'b1;
      if (mod_evt)               cause_r[`CAUSE_MOD_BIT] <= 1'b1;
      if (LOW_SUPPLY)            cause_r[`CAUSE_LVI_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus clock divider, quarter rate
  logic [1:0] div_r;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      div_r <= 2'h0;
    end else if (ctrl_r[`CTRL_PLLSEL_BIT] && !PLL_LOCKED) begin
      div_r <= 2'h0;                                 // pll source not ready
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  assign pin_driving = state_r == ST_POWER_WAIT || state_r == ST_PIN_DRIVE;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RESET_PIN_N_OUT  <= 1'b0;
      RESET_PIN_N_OE_N <= 1'b0;
      INTERNAL_RESET   <= 1'b1;
      CLOCK_GEN_OUTPUT <= 1'b1;
      CPU_CLK_EN       <= 1'b0;
      PERIPH_CLK_EN    <= 1'b0;
      WATCHDOG_ENABLE  <= 1'b1;
      RESET_VECTOR     <= `VEC_USER;
    end else begin
      RESET_PIN_N_OUT  <= 1'b0;
      RESET_PIN_N_OE_N <= !pin_driving;
      INTERNAL_RESET   <= state_r inside {ST_POWER_WAIT, ST_PIN_DRIVE, ST_INTERNAL_RESET_TAIL}
                          || int_evt;
      CLOCK_GEN_OUTPUT <= 1'b1;
      CPU_CLK_EN       <= state_r == ST_RUN && !WAIT_INSTR && div_r == 2'h3;
      PERIPH_CLK_EN    <= state_r == ST_RUN && div_r == 2'h3;
      WATCHDOG_ENABLE  <= !wdg_dis;
      RESET_VECTOR     <= MONITOR_MODE ? `VEC_MONITOR : `VEC_USER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        `CAUSE_ADDR: RDATA <= cause_r;
        `CTRL_ADDR:  RDATA <= ctrl_r;
        `STAT_ADDR:  RDATA <= {5'h00, state_r};
        default:     RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule : reset_clock_sequencer
`default_nettype wire

// >>> rcs_properties.sv
// port checker for the reset and clock sequencer
// assumes a bind from the bench top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module rcs_properties (
  // watched ports
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        POWER_ON,
  input wire logic        LOW_SUPPLY,
  input wire logic        WATCHDOG_OVF,
  input wire logic        BAD_OPCODE,
  input wire logic        MONITOR_MODE,
  input wire logic        BREAK_STATE,
  input wire logic        RST_PIN_HV,
  input wire logic        IRQ_PIN_HV,
  input wire logic        RESET_PIN_N_OE_N,
  input wire logic        INTERNAL_RESET,
  input wire logic        CPU_CLK_EN,
  input wire logic        PERIPH_CLK_EN,
  input wire logic        WATCHDOG_ENABLE,
  input wire logic [15:0] RESET_VECTOR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////
  // disable decode, only high voltage can switch the watchdog off
  wire logic wd_off = (MONITOR_MODE && (RST_PIN_HV || IRQ_PIN_HV)) || (BREAK_STATE && RST_PIN_HV);
  // two steps of an internal reset: pin phase, then the tail
  sequence pin_s;
    ##31 !RESET_PIN_N_OE_N ##1 RESET_PIN_N_OE_N;
  endsequence
  sequence tail_s;
    INTERNAL_RESET ##[32:33] !INTERNAL_RESET;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  pin_needs_internal_reset_a: assert property (!RESET_PIN_N_OE_N |-> INTERNAL_RESET)
    else $error("pin driven without internal reset");
  clocks_gated_a: assert property (INTERNAL_RESET && $past(INTERNAL_RESET) |->
    !CPU_CLK_EN && !PERIPH_CLK_EN) else $error("bus clocks run in reset");
  vector_sel_a: assert property (INTERNAL_RESET && $past(INTERNAL_RESET) &&
    $stable(MONITOR_MODE) |-> RESET_VECTOR == (MONITOR_MODE ? 16'hFEFE : 16'hFFFE))
    else $error("wrong reset vector");
  bus_quarter_a: assert property (PERIPH_CLK_EN |=> !PERIPH_CLK_EN [*3])
    else $error("bus clock not one in four");
  internal_seq_a: assert property ($fell(RESET_PIN_N_OE_N) && !$past(POWER_ON) &&
    !$past(LOW_SUPPLY) && !LOW_SUPPLY && !$past(POWER_ON, 2) && !$past(LOW_SUPPLY, 2)
    |-> pin_s ##0 tail_s)
    else $error("internal reset sequence length");
  wd_disable_a: assert property ($past(RESETN) |-> WATCHDOG_ENABLE == !$past(wd_off))
    else $error("watchdog enable decode");
  wd_reset_a: assert property ($rose(WATCHDOG_OVF) && !wd_off && WATCHDOG_ENABLE &&
    !INTERNAL_RESET |-> ##[2:8] INTERNAL_RESET) else $error("watchdog without reset");
  opcode_rst_a: assert property (BAD_OPCODE && !INTERNAL_RESET |-> ##[1:3] INTERNAL_RESET)
    else $error("bad opcode without reset");
endmodule : rcs_properties
`default_nettype wire

// >>> reset_pin_model.sv
// reset pin with its pull-up and an outside party that can pull it low
// assumes the sequencer only ever drives the pin low, enable active low
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model (
  // pin parties
  input  wire logic oe_n,
  input  wire logic drv,
  input  wire logic ext_low,
  // resolved level
  output logic      level
);
  // wired low, pull-up wins only when nobody pulls
  assign level = ((!oe_n && !drv) || ext_low) ? 1'b0 : 1'b1;
endmodule : reset_pin_model
`default_nettype wire

// >>> reset_clock_sequencer_tb_top.sv
// self-checking bench for the reset and clock sequencer
// assumes the pin model beside it and the checker bound below
`timescale 1ns/1ps
`default_nettype none
module reset_clock_sequencer_tb_top;
  import rcs_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, exp;
  logic [8:0] p = 9'h000;
  logic mon = 1'b0, rhv = 1'b0, ihv = 1'b0, brk = 1'b0, pll = 1'b0, por = 1'b0, ext = 1'b0;
  logic pin_out, oe_n, pin, internal_reset, cgo, cpu_en, per_en, wde;
  logic [15:0] vec;
  logic [8:0] msk [6] = '{9'h002, 9'h00C, 9'h010, 9'h020, 9'h100, 9'h001};
  logic [7:0] flg [6] = '{8'h10, 8'h08, 8'h20, 8'h04, 8'h02, 8'h10};
  int fails = 0;
  int num_checks = 0;
  // free-running reference clock
  always #5 clock = ~clock;
  reset_pin_model pin_u (.oe_n(oe_n), .drv(pin_out), .ext_low(ext), .level(pin));
  reset_clock_sequencer dut_u (.CLOCK(clock), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .POWER_ON(por), .LOW_SUPPLY(p[8]),
    .WATCHDOG_OVF(p[4]), .BAD_OPCODE(p[0]), .STOP_INSTR(p[1]), .WAIT_INSTR(p[7]),
    .OPCODE_FETCH(p[2]), .UNMAPPED_ADDR(p[3]), .MONITOR_MODE(mon), .VECTORS_ERASED(p[5]),
    .BREAK_STATE(brk), .WAKE_EVENT(p[6]), .PLL_LOCKED(pll), .RST_PIN_HV(rhv),
    .IRQ_PIN_HV(ihv), .RESET_PIN_N_IN(pin), .RESET_PIN_N_OUT(pin_out),
    .RESET_PIN_N_OE_N(oe_n), .INTERNAL_RESET(internal_reset), .CLOCK_GEN_OUTPUT(cgo),
    .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .WATCHDOG_ENABLE(wde), .RESET_VECTOR(vec));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [15:0] seen, logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic results();
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // one-cycle write, strobe dropped at the next edge
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // data stand only in the cycle after the strobe
  task automatic rd_chk(logic [7:0] a, logic [7:0] want);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check("rdata", 16'(rdata), 16'(want));
  endtask : rd_chk
  task automatic pulse(logic [8:0] m, int len);
    @(posedge clock);
    p <= m;
    repeat (len) @(posedge clock);
    p <= 9'h000;
  endtask : pulse
  // cycles until pin released, reset ended or bus clock seen
  task automatic cnt(int sel, int lim, output int n);
    logic [2:0] v;
    n = 0;
    v = {per_en, ~internal_reset, oe_n};
    while (v[sel] !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1 v = {per_en, ~internal_reset, oe_n};
      n++;
    end
  endtask : cnt
  task automatic wait_rst();
    int n;
    repeat (20) @(posedge clock);
    cnt(1, 9000, n);
    check("reset end", 16'(n < 9000), 16'h0001);
  endtask : wait_rst
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    cnt(0, 5000, n);
    check("pin hold", 16'(n inside {[4127:4131]}), 16'h0001);
    cnt(1, 100, n);
    check("internal_reset tail", 16'(n inside {[31:34]}), 16'h0001);
    check("clock out", 16'(cgo), 16'h0001);
    exp = 8'h80;
    rd_chk(8'h00, exp);
    wr_reg(8'h00, 8'h00);
    rd_chk(8'h00, exp);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h0C, 8'h00);
    // wait mode keeps peripheral clock only
    @(posedge clock) p <= 9'h080;
    repeat (2) @(posedge clock);
    n = 0;
    repeat (16) @(posedge clock) n += 16'(per_en) + 16'(cpu_en) * 100;
    check("wait clocks", 16'(n), 16'h0004);
    p <= 9'h000;
    pulse(9'h040, 1);
    // stop recovery, short then long
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h04, k ? 8'h02 : 8'h03);
      pulse(9'h002, 1);
      repeat (40) @(posedge clock);
      check("stop gate", 16'(per_en | cpu_en), 16'h0000);
      pulse(9'h040, 1);
      cnt(2, 5000, n);
      check("wake", 16'(n - (k ? 4096 : 32) inside {[-2:6]}), 16'h0001);
    end
    // data access to unmapped space and disabled watchdog: no reset
    pulse(9'h008, 4);
    @(posedge clock) {mon, rhv} <= 2'b11;
    pulse(9'h010, 4);
    repeat (10) @(posedge clock);
    check("no reset", 16'({internal_reset, wde}), 16'h0000);
    @(posedge clock) {mon, brk} <= 2'b01;
    repeat (3) @(posedge clock);
    check("break wd", 16'(wde), 16'h0000);
    @(posedge clock) {brk, rhv} <= 2'b00;
    wr_reg(8'h04, 8'h00);
    // each source in turn, flags accumulate
    for (int k = 0; k < 6; k++) begin
      @(posedge clock) mon <= (k == 3);
      pulse(msk[k], 1);
      wait_rst();
      exp |= flg[k];
      rd_chk(8'h00, exp);
    end
    @(posedge clock) mon <= 1'b0;
    // external pin: too short, then long enough
    for (int k = 0; k < 2; k++) begin
      @(posedge clock) ext <= 1'b1;
      repeat (k ? 80 : 40) @(posedge clock);
      ext <= 1'b0;
      wait_rst();
      exp |= k ? 8'h40 : 8'h00;
      rd_chk(8'h00, exp);
    end
    results();
  end
  // hang guard, far beyond the longest expected run
  initial begin
    #400us;
    fails++;
    results();
  end
endmodule : reset_clock_sequencer_tb_top
bind reset_clock_sequencer rcs_properties props_u (.CLOCK(CLOCK), .RESETN(RESETN),
  .POWER_ON(POWER_ON), .LOW_SUPPLY(LOW_SUPPLY), .WATCHDOG_OVF(WATCHDOG_OVF),
  .BAD_OPCODE(BAD_OPCODE), .MONITOR_MODE(MONITOR_MODE), .BREAK_STATE(BREAK_STATE),
  .RST_PIN_HV(RST_PIN_HV), .IRQ_PIN_HV(IRQ_PIN_HV), .RESET_PIN_N_OE_N(RESET_PIN_N_OE_N),
  .INTERNAL_RESET(INTERNAL_RESET), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .RESET_VECTOR(RESET_VECTOR));
`default_nettype wire
